// ==== rtl/sssx_exec.sv ====
// Contract
// - Literal minus accumulator into accumulator
// - Decode 11 110x literal form, x ignored
// - Subtracts update carry, digit carry, zero
// - Literal subtract in one four-phase cycle
// - File minus accumulator to selected destination
// - Negative result clears carry and zero
// - Zero result sets zero and carry
// - Swap exchanges file nibbles, flags untouched
// - Swap result to accumulator or file
// - Sleep: decode, two idle phases, sleep
// - Sleep clears power-down, sets time-out, clears watchdog, stops oscillator
`timescale 1ns/10ps
`default_nettype none
module sssx_exec
   import sssx_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_srst,
   input  wire logic [13:0] i_instr,
   input  wire logic [7:0]  i_file_rdata,
   output logic      [6:0]  o_file_addr,
   output logic             o_file_rd,
   output logic      [7:0]  o_file_wdata,
   output logic             o_file_we,
   output logic      [7:0]  o_acc,
   output logic             o_carry_flag,
   output logic             o_digit_carry_flag,
   output logic             o_zero_flag,
   output logic             o_power_down_status_n,
   output logic             o_time_out_status_n,
   output logic             o_watchdog_clear,
   output logic             o_osc_stop,
   output logic      [1:0]  o_phase,
   output logic             o_busy_unknown
);
   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   function automatic sssx_op_t sssx_decode(input logic [13:0] instr);
      sssx_op_t op;
      op = SSSX_OP_NONE;
      if ((instr & SSSX_SUBLIT_MASK) == SSSX_SUBLIT_MATCH) begin
         op = SSSX_OP_SUBLIT;
      end else if ((instr & SSSX_FILEOP_MASK) == SSSX_SUBFILE_MATCH) begin
         op = SSSX_OP_SUBFILE;
      end else if ((instr & SSSX_FILEOP_MASK) == SSSX_SWAP_MATCH) begin
         op = SSSX_OP_SWAP;
      end else if (instr == SSSX_SLEEP_CODE) begin
         op = SSSX_OP_SLEEP;
      end
      return op;
   endfunction : sssx_decode

   sssx_phase_t phase_q;
   sssx_op_t    op_q;
   logic [13:0] instr_q;
   logic [7:0]  operand_q;
   logic [7:0]  result_q;
   logic        carry_res_q;
   logic        digc_res_q;
   logic        zero_res_q;
   logic        asleep_q;
   logic [7:0]  acc_q;
   logic        c_q;
   logic        digc_q;
   logic        z_q;
   logic        pwrdn_n_q;
   logic        tmout_n_q;
   logic        wdog_clr_q;
   logic [7:0]  wdata_q;
   logic        we_q;
   logic        rd_q;
   logic        unknown_q;

   wire sssx_op_t   op_dec;
   wire logic       dest_file;
   wire logic [7:0] swapped;
   wire logic [7:0] diff;
   wire logic       diff_c;
   wire logic       diff_digc;
   wire logic       unknown_d;
   wire logic       diff_z;
   wire logic       is_sub;
   wire logic       is_file_op;

   assign op_dec     = sssx_decode(i_instr);
   assign dest_file  = instr_q[SSSX_DEST_BIT];
   assign is_sub     = (op_q == SSSX_OP_SUBLIT) || (op_q == SSSX_OP_SUBFILE);
   assign is_file_op = (op_q == SSSX_OP_SUBFILE) || (op_q == SSSX_OP_SWAP);
   assign swapped    = {operand_q[SSSX_NIB_LSB-1:0], operand_q[7:SSSX_NIB_LSB]};

   sssx_alu u_alu (
      .i_minuend     (operand_q),
      .i_subtrahend  (acc_q),
      .o_diff        (diff),
      .o_carry       (diff_c),
      .o_digit_carry (diff_digc),
      .o_zero        (diff_z)
   );

   // ---------------------------------------------------------------
   // Phase sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         phase_q <= SSSX_Q1;
      end else if (!asleep_q) begin
         case (phase_q)
            SSSX_Q1: phase_q <= SSSX_Q2;
            SSSX_Q2: phase_q <= SSSX_Q3;
            SSSX_Q3: phase_q <= SSSX_Q4;
            SSSX_Q4: phase_q <= SSSX_Q1;
            default: phase_q <= SSSX_Q1;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Datapath
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         op_q        <= SSSX_OP_NONE;
         instr_q     <= 14'h0000;
         operand_q   <= 8'h00;
         result_q    <= 8'h00;
         carry_res_q <= 1'b0;
         digc_res_q  <= 1'b0;
         zero_res_q  <= 1'b0;
         rd_q        <= 1'b0;
      end else if (!asleep_q) begin
         rd_q <= 1'b0;
         case (phase_q)
            SSSX_Q1: begin
               op_q    <= op_dec;
               instr_q <= i_instr;
               rd_q    <= (op_dec == SSSX_OP_SUBFILE) || (op_dec == SSSX_OP_SWAP);
            end
            SSSX_Q2: begin
               if (op_q == SSSX_OP_SUBLIT) begin
                  operand_q <= instr_q[SSSX_LIT_MSB:0];
               end else if (is_file_op) begin
                  operand_q <= i_file_rdata;
               end
            end
            SSSX_Q3: begin
               result_q    <= (op_q == SSSX_OP_SWAP) ? swapped : diff;
               carry_res_q <= diff_c;
               digc_res_q  <= diff_digc;
               zero_res_q  <= diff_z;
            end
            SSSX_Q4: op_q <= op_q;
            default: op_q <= SSSX_OP_NONE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Write back and status
   // ---------------------------------------------------------------
   wire logic wb     = !asleep_q && (phase_q == SSSX_Q4);
   wire logic to_acc = wb && ((op_q == SSSX_OP_SUBLIT) || (is_file_op && !dest_file));
   wire logic to_fil = wb && is_file_op && dest_file;
   wire logic slp    = wb && (op_q == SSSX_OP_SLEEP);

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         acc_q      <= SSSX_ACC_RST;
         c_q        <= 1'b0;
         digc_q     <= 1'b0;
         z_q        <= 1'b0;
         pwrdn_n_q  <= SSSX_PWRDN_RST;
         tmout_n_q  <= SSSX_TMOUT_RST;
         asleep_q   <= 1'b0;
         wdog_clr_q <= 1'b0;
         we_q       <= 1'b0;
         wdata_q    <= 8'h00;
      end else begin
         we_q       <= to_fil;
         wdog_clr_q <= slp;
         if (to_fil) begin
            wdata_q <= result_q;
         end
         if (to_acc) begin
            acc_q <= result_q;
         end
         if (wb && is_sub) begin
            c_q    <= carry_res_q;
            digc_q <= digc_res_q;
            z_q    <= zero_res_q;
         end
         if (slp) begin
            pwrdn_n_q <= 1'b0;
            tmout_n_q <= 1'b1;
            asleep_q  <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Foreign opcode flag
   // ---------------------------------------------------------------
   // Tracks the opcode latched in Q1; quiet once asleep
   assign unknown_d = !asleep_q && !slp &&
                      ((phase_q == SSSX_Q1) ? (op_dec == SSSX_OP_NONE) : (op_q == SSSX_OP_NONE));

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         unknown_q <= 1'b1;
      end else begin
         unknown_q <= unknown_d;
      end
   end

   assign o_file_addr           = instr_q[SSSX_ADDR_MSB:0];
   assign o_file_rd             = rd_q;
   assign o_file_wdata          = wdata_q;
   assign o_file_we             = we_q;
   assign o_acc                 = acc_q;
   assign o_carry_flag          = c_q;
   assign o_digit_carry_flag    = digc_q;
   assign o_zero_flag           = z_q;
   assign o_power_down_status_n = pwrdn_n_q;
   assign o_time_out_status_n   = tmout_n_q;
   assign o_watchdog_clear      = wdog_clr_q;
   assign o_osc_stop            = asleep_q;
   assign o_phase               = phase_q;
   assign o_busy_unknown        = unknown_q;
endmodule : sssx_exec
`default_nettype wire

// ==== rtl/sssx_pkg.sv ====
package sssx_pkg;
   // ---------------------------------------------------------------
   // Instruction encodings
   // ---------------------------------------------------------------
   localparam logic [13:0] SSSX_SUBLIT_MASK  = 14'h3e00;
   localparam logic [13:0] SSSX_SUBLIT_MATCH = 14'h3c00;
   localparam logic [13:0] SSSX_FILEOP_MASK  = 14'h3f00;
   localparam logic [13:0] SSSX_SUBFILE_MATCH = 14'h0200;
   localparam logic [13:0] SSSX_SWAP_MATCH   = 14'h0e00;
   localparam logic [13:0] SSSX_SLEEP_CODE   = 14'h0063;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int SSSX_DEST_BIT  = 7;
   localparam int SSSX_ADDR_MSB  = 6;
   localparam int SSSX_LIT_MSB   = 7;
   localparam int SSSX_NIB_LSB   = 4;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] SSSX_ACC_RST   = 8'h00;
   localparam logic [7:0] SSSX_WDOG_CLEAR = 8'h00;
   localparam logic       SSSX_TMOUT_RST  = 1'b1;
   localparam logic       SSSX_PWRDN_RST  = 1'b1;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SSSX_OP_NONE,
      SSSX_OP_SUBLIT,
      SSSX_OP_SUBFILE,
      SSSX_OP_SWAP,
      SSSX_OP_SLEEP
   } sssx_op_t;
   typedef enum logic [1:0] {
      SSSX_Q1,
      SSSX_Q2,
      SSSX_Q3,
      SSSX_Q4
   } sssx_phase_t;
endpackage : sssx_pkg

// ==== rtl/sssx_alu.sv ====
`timescale 1ns/10ps
`default_nettype none
module sssx_alu
   import sssx_pkg::*;
(
   input  wire logic [7:0] i_minuend,
   input  wire logic [7:0] i_subtrahend,
   output logic      [7:0] o_diff,
   output logic            o_carry,
   output logic            o_digit_carry,
   output logic            o_zero
);
   wire logic [8:0] full_sum;
   wire logic [4:0] low_sum;
   // Two's complement: a + ~b + 1
   assign full_sum = {1'b0, i_minuend} + {1'b0, ~i_subtrahend} + 9'h001;
   assign low_sum  = {1'b0, i_minuend[3:0]} + {1'b0, ~i_subtrahend[3:0]} + 5'h01;
   assign o_diff        = full_sum[7:0];
   assign o_carry       = full_sum[8];
   assign o_digit_carry = low_sum[4];
   assign o_zero        = (full_sum[7:0] == 8'h00);
endmodule : sssx_alu
`default_nettype wire

// ==== verification/sssx_exec_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module sssx_exec_checker
   import sssx_pkg::*;
(
   input wire logic        i_clock,
   input wire logic        i_srst,
   input wire logic [13:0] i_instr,
   input wire logic [7:0]  i_file_rdata,
   input wire logic [6:0]  o_file_addr,
   input wire logic        o_file_rd,
   input wire logic [7:0]  o_file_wdata,
   input wire logic        o_file_we,
   input wire logic [7:0]  o_acc,
   input wire logic        o_carry_flag,
   input wire logic        o_digit_carry_flag,
   input wire logic        o_zero_flag,
   input wire logic        o_power_down_status_n,
   input wire logic        o_time_out_status_n,
   input wire logic        o_watchdog_clear,
   input wire logic        o_osc_stop,
   input wire logic [1:0]  o_phase
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_srst);
   wire        q1    = o_phase == 2'h0 && !o_osc_stop;
   wire [13:0] hi    = i_instr & SSSX_FILEOP_MASK;
   wire        lit   = q1 && (i_instr & SSSX_SUBLIT_MASK) == SSSX_SUBLIT_MATCH;
   wire        sub   = q1 && hi == SSSX_SUBFILE_MATCH;
   wire        swp   = q1 && hi == SSSX_SWAP_MATCH;
   wire        slp   = q1 && i_instr == SSSX_SLEEP_CODE;
   wire [2:0]  flags = {o_carry_flag, o_digit_carry_flag, o_zero_flag};
   AST_LIT_ACC: assert property (lit |-> ##4 o_acc == 8'($past(i_instr[7:0], 4) - $past(o_acc, 4)))
      else $error("literal subtract result wrong");
   AST_LIT_FLAGS: assert property (lit |-> ##4 flags == {$past(i_instr[7:0], 4) >= $past(o_acc, 4),
      $past(i_instr[3:0], 4) >= $past(o_acc[3:0], 4), o_acc == 8'h00})
      else $error("literal subtract flags wrong");
   AST_FILE_RD: assert property (sub || swp |=> o_file_rd && o_file_addr == $past(i_instr[6:0]))
      else $error("file read missing");
   AST_FILE_WR: assert property (sub && i_instr[7] |-> ##4 o_file_we
      && o_file_wdata == 8'($past(i_file_rdata, 3) - $past(o_acc, 4)))
      else $error("file subtract write wrong");
   AST_FILE_ACC: assert property (sub && !i_instr[7] |-> ##4 !o_file_we
      && o_acc == 8'($past(i_file_rdata, 3) - $past(o_acc, 4)))
      else $error("file subtract to acc wrong");
   AST_SWAP_RES: assert property (swp |-> ##4 o_file_we == $past(i_instr[7], 4)
      && (o_file_we ? o_file_wdata : o_acc) == {$past(i_file_rdata[3:0], 3),
      $past(i_file_rdata[7:4], 3)})
      else $error("swap result wrong");
   AST_SWAP_FLAGS: assert property (swp |=> $stable(flags) [*4])
      else $error("swap changed flags");
   AST_SLEEP: assert property (slp |=> !o_osc_stop [*3] ##1 (o_osc_stop && o_watchdog_clear
      && !o_power_down_status_n && o_time_out_status_n))
      else $error("sleep sequence wrong");
   AST_PHASE: assert property (!o_osc_stop |=> o_phase == $past(o_phase) + 2'h1)
      else $error("phase did not advance");
   cover property (slp);
   cover property (swp && i_instr[7]);
   cover property (lit && i_instr[8]);
endmodule : sssx_exec_checker
bind sssx_exec sssx_exec_checker u_chk (
   .i_clock               (i_clock),
   .i_srst                (i_srst),
   .i_instr               (i_instr),
   .i_file_rdata          (i_file_rdata),
   .o_file_addr           (o_file_addr),
   .o_file_rd             (o_file_rd),
   .o_file_wdata          (o_file_wdata),
   .o_file_we             (o_file_we),
   .o_acc                 (o_acc),
   .o_carry_flag          (o_carry_flag),
   .o_digit_carry_flag    (o_digit_carry_flag),
   .o_zero_flag           (o_zero_flag),
   .o_power_down_status_n (o_power_down_status_n),
   .o_time_out_status_n   (o_time_out_status_n),
   .o_watchdog_clear      (o_watchdog_clear),
   .o_osc_stop            (o_osc_stop),
   .o_phase               (o_phase)
);
`default_nettype wire

// ==== verification/sssx_file_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module sssx_file_model (
   input  wire logic       i_clock,
   input  wire logic [6:0] i_addr,
   input  wire logic       i_rd,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_we,
   output logic      [7:0] o_rdata
);
   logic [7:0] mem [128];
   logic [7:0] last_q = 8'h00;
   // Released bus shows inverse of last read
   assign o_rdata = i_rd ? mem[i_addr] : ~last_q;
   always @(posedge i_clock) begin
      if (i_we) mem[i_addr] <= i_wdata;
      if (i_rd) last_q <= o_rdata;
   end
endmodule : sssx_file_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import sssx_pkg::*;
;
   logic        i_clock = 1'b0;
   logic        i_srst  = 1'b1;
   logic [13:0] i_instr = 14'h0000;
   wire  [7:0]  rd, wd, acc;
   wire  [6:0]  fa;
   wire  [1:0]  ph;
   wire         frd, we, c, dcf, z, pwrdn_n, tmo_n, wdc, osc, bu;
   int          failures = 0;
   int          n_checks = 0;
   logic [24:0] tab [8] = '{{14'h3c02, 8'h02, 3'h6}, {14'h3d03, 8'h01, 3'h6},
      {14'h3c01, 8'h00, 3'h7}, {14'h3c02, 8'h02, 3'h6}, {14'h3c01, 8'hff, 3'h0},
      {14'h3cff, 8'h00, 3'h7}, {14'h3c01, 8'h01, 3'h6}, {14'h3c10, 8'h0f, 3'h4}};
   always #12.5 i_clock = ~i_clock;
   sssx_exec DUT (.i_clock(i_clock), .i_srst(i_srst), .i_instr(i_instr), .i_file_rdata(rd),
      .o_file_addr(fa), .o_file_rd(frd), .o_file_wdata(wd), .o_file_we(we), .o_acc(acc),
      .o_carry_flag(c), .o_digit_carry_flag(dcf), .o_zero_flag(z),
      .o_power_down_status_n(pwrdn_n), .o_time_out_status_n(tmo_n), .o_watchdog_clear(wdc),
      .o_osc_stop(osc), .o_phase(ph), .o_busy_unknown(bu));
   sssx_file_model PM (.i_clock(i_clock), .i_addr(fa), .i_rd(frd), .i_wdata(wd), .i_we(we),
      .o_rdata(rd));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out
   task automatic ex(input logic [13:0] ins);
      int k;
      k = 0;
      while (ph !== 2'h0 && k < 8) begin
         @(negedge i_clock);
         k++;
      end
      if (ph !== 2'h0) begin
         failures++;
         close_out();
      end
      i_instr = ins;
      @(negedge i_clock);
      i_instr = 14'h0000;
      repeat (3) @(negedge i_clock);
   endtask : ex
   task automatic res(input logic [7:0] ea, input logic [2:0] ef, input logic ew);
      chk("acc", ea, acc);
      chk("flags", {5'h00, ef}, {5'h00, c, dcf, z});
      chk("we", {7'h00, ew}, {7'h00, we});
   endtask : res
   task automatic s_sublit;
      for (int i = 0; i < 8; i++) begin
         ex(tab[i][24:11]);
         res(tab[i][10:3], tab[i][2:0], 1'b0);
      end
   endtask : s_sublit
   task automatic s_sub_from_file_op;
      PM.mem[5] = 8'h2f;
      PM.mem[6] = 8'h0f;
      ex(14'h0285);
      res(8'h0f, 3'h6, 1'b1);
      chk("wdata", 8'h20, wd);
      ex(14'h0206);
      res(8'h00, 3'h7, 1'b0);
   endtask : s_sub_from_file_op
   task automatic s_swap;
      PM.mem[7'h12] = 8'ha5;
      PM.mem[7'h13] = 8'h3c;
      ex(14'h0e12);
      res(8'h5a, 3'h7, 1'b0);
      ex(14'h0e93);
      res(8'h5a, 3'h7, 1'b1);
      chk("wdata", 8'hc3, wd);
      chk("unknown", 8'h00, {7'h00, bu});
   endtask : s_swap
   task automatic s_sleep;
      ex(14'h0700);
      res(8'h5a, 3'h7, 1'b0);
      chk("unknown", 8'h01, {7'h00, bu});
      ex(SSSX_SLEEP_CODE);
      chk("sleep", 8'h07, {4'h0, pwrdn_n, tmo_n, osc, wdc});
      i_instr = 14'h3c55;
      repeat (8) @(negedge i_clock);
      chk("asleep", 8'h06, {4'h0, pwrdn_n, tmo_n, osc, wdc});
      chk("acc", 8'h5a, acc);
      i_srst = 1'b1;
      i_instr = 14'h0000;
      repeat (2) @(negedge i_clock);
      i_srst = 1'b0;
      chk("wake", 8'h0c, {4'h0, pwrdn_n, tmo_n, osc, wdc});
   endtask : s_sleep
   initial begin
      repeat (20) @(negedge i_clock);
      chk("rst", 8'h0c, {4'h0, pwrdn_n, tmo_n, osc, wdc});
      i_srst = 1'b0;
      s_sublit();
      s_sub_from_file_op();
      s_swap();
      s_sleep();
      close_out();
   end
endmodule : tb_top
`default_nettype wire
